// ==== hw/tps_pkg.sv ====
// Shared constants and types of the test pattern source.
package tps_pkg;

  // Pseudo-random orders and their feedback taps.
  localparam int PRBS_COUNT = 5;
  localparam logic [4:0] PRBS_ORDER [0:4] = '{5'd7, 5'd15, 5'd17, 5'd20, 5'd23};
  localparam logic [4:0] PRBS_TAP [0:4] = '{5'd6, 5'd14, 5'd14, 5'd17, 5'd18};
  localparam int PRBS_MAX_ORDER = 23;
  localparam logic [22:0] PRBS_SEED = 23'h7fffff;

  // Mark density generator taps into its own 23-bit register.
  localparam int MARK_TAP_A = 22;
  localparam int MARK_TAP_B = 14;
  localparam int MARK_TAP_C = 5;

  // Word storage geometry.
  localparam int WORD_SAVED_SLOTS = 8;
  localparam logic [3:0] WORD_CURRENT_SLOT = 4'h8;
  localparam int WORD_SLOTS = 9;
  localparam int WORD_BYTES_EXT = 16384;
  localparam logic [16:0] WORD_LEN_M1_BASIC = 17'h0000f;
  localparam logic [13:0] WORD_BYTES_BASIC_LAST = 14'h0001;

  // Read-only patterns: count, length and contents fixed at build time.
  localparam int PROM_COUNT = 10;
  localparam logic [16:0] PROM_LEN_M1 = 17'h0000f;
  localparam logic [15:0] PROM_PATTERN [0:9] = '{
    16'h00ff, 16'hf0f0, 16'hcccc, 16'haaaa, 16'h8001,
    16'h7ffe, 16'h0f0f, 16'h3333, 16'h5555, 16'hff00
  };

  // Recall list: word slots, mark densities, read-only patterns.
  localparam logic [4:0] RECALL_MARK_FIRST = 5'h08;
  localparam logic [4:0] RECALL_PROM_FIRST = 5'h0d;
  localparam logic [4:0] RECALL_LAST_BASIC = 5'h07;
  localparam logic [4:0] RECALL_LAST_EXT = 5'h0c;
  localparam logic [4:0] RECALL_LAST_PROM = 5'h16;
  localparam logic [2:0] PRBS_LAST = 3'h4;

  // Display label codes.
  localparam logic [4:0] prbs_order7_label = 5'h00;
  localparam logic [4:0] prbs_order15_label = 5'h01;
  localparam logic [4:0] prbs_order17_label = 5'h02;
  localparam logic [4:0] prbs_order20_label = 5'h03;
  localparam logic [4:0] prbs_order23_label = 5'h04;
  localparam logic [4:0] CURRENT_WORD_LABEL = 5'h05;
  localparam logic [4:0] WORD_SLOT0_LABEL = 5'h06;
  localparam logic [4:0] eighth_ones_density_label = 5'h0e;
  localparam logic [4:0] quarter_ones_density_label = 5'h0f;
  localparam logic [4:0] half_ones_density_label = 5'h10;
  localparam logic [4:0] three_quarter_ones_density_label = 5'h11;
  localparam logic [4:0] seven_eighth_ones_density_label = 5'h12;
  localparam logic [4:0] PROM0_LABEL = 5'h13;

  // Key synchroniser bit positions.
  localparam int KEY_LOCK = 0;
  localparam int KEY_PRBS = 1;
  localparam int KEY_WORD = 2;
  localparam int KEY_RECALL = 3;
  localparam int KEY_UP = 4;
  localparam int KEY_DOWN = 5;
  localparam int KEY_EXT_OPT = 6;
  localparam int KEY_PROM_OPT = 7;
  localparam int KEY_COUNT = 8;

  typedef enum logic [1:0] {
    MODE_PRBS,
    MODE_WORD,
    MODE_RECALL
  } tps_mode_t;

  typedef enum logic [1:0] {
    SRC_PRBS,
    SRC_WORD,
    SRC_MARK,
    SRC_PROM
  } tps_src_t;

endpackage : tps_pkg

// ==== hw/tps_prbs.sv ====
// Maximal-length shift register for the selectable pseudo-random orders.
`timescale 1ns/1ps
module tps_prbs
  import tps_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic restart_i,
  input wire logic [2:0] order_sel_i,
  output logic bit_o
);

  logic [22:0] state_reg;
  logic [22:0] state_next;
  logic [22:0] mask_w;
  logic [4:0] order_w;
  logic [4:0] tap_w;
  logic feedback_w;

  assign order_w = PRBS_ORDER[order_sel_i];
  assign tap_w = PRBS_TAP[order_sel_i];
  assign mask_w = PRBS_SEED >> (5'd23 - order_w);
  assign feedback_w = state_reg[order_w - 5'd1] ^ state_reg[tap_w - 5'd1];
  assign state_next = {state_reg[21:0], feedback_w} & mask_w;
  assign bit_o = state_reg[order_w - 5'd1];

  always_ff @(posedge clk_i) begin
    if (!resetn_i || restart_i) begin
      state_reg <= PRBS_SEED;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : tps_prbs

// ==== hw/tps_mark.sv ====
// Randomised mark density source built from a free pseudo-random register.
`timescale 1ns/1ps
module tps_mark
  import tps_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic restart_i,
  input wire logic [2:0] density_sel_i,
  output logic bit_o
);

  logic [22:0] state_reg;
  logic a_w;
  logic b_w;
  logic c_w;

  assign a_w = state_reg[MARK_TAP_A];
  assign b_w = state_reg[MARK_TAP_B];
  assign c_w = state_reg[MARK_TAP_C];

  // Combining near-independent random bits gives the density in eighths.
  always_comb begin
    case (density_sel_i)
      3'h0: bit_o = a_w & b_w & c_w;
      3'h1: bit_o = a_w & b_w;
      3'h2: bit_o = a_w;
      3'h3: bit_o = a_w | b_w;
      3'h4: bit_o = a_w | b_w | c_w;
      default: bit_o = a_w;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i || restart_i) begin
      state_reg <= PRBS_SEED;
    end else begin
      state_reg <= {state_reg[21:0], state_reg[22] ^ state_reg[17]};
    end
  end

endmodule : tps_mark

// ==== hw/tps_source.sv ====
// Pattern selection, lockout, word storage and bit output of the pattern source.
`timescale 1ns/1ps

// Functional notes
// - A pseudo-random sequence of order n repeats every 2^n-1 bits.
// - Longest zero run in an order n sequence is n-1 bits.
// - Only orders 7, 15, 17, 20 and 23 are offered, each labelled.
// - One full period holds one more one than zeros.
// - Mark patterns are randomised, not fixed runs of zeros.
// - Mark patterns are selectable only with extended memory fitted.
// - Basic build keeps eight retained word slots of up to 16 bits.
// - Extended memory lets each saved word reach 128 kbit.
// - The current word is also retained, in both builds.
// - With the read-only and extended memory options both fitted, ten fixed patterns are selectable.
// - Generator and analyzer use the same patterns and selection.
// - While locked, every setup-changing key and write is ignored.
// - The lock key toggles the lock; the indicator is lit while locked.
// - A displayed pseudo-random choice becomes active at once.
// - Recall list is words 0-7, five densities, fixed 0-9; active at once.
module tps_source
  import tps_pkg::*;
#(
  parameter int WORD_BYTES = WORD_BYTES_EXT
)
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic lock_key_i,
  input wire logic prbs_key_i,
  input wire logic word_key_i,
  input wire logic recall_key_i,
  input wire logic up_key_i,
  input wire logic down_key_i,
  input wire logic extended_memory_option_i,
  input wire logic prom_option_i,
  input wire logic wr_en_i,
  input wire logic [3:0] wr_slot_i,
  input wire logic [13:0] wr_byte_i,
  input wire logic [7:0] wr_data_i,
  input wire logic len_wr_i,
  input wire logic [16:0] len_m1_i,
  output logic pattern_bit_o,
  output logic restart_o,
  output logic lock_led_o,
  output logic [4:0] display_label_o,
  output logic [1:0] active_source_o
);

  if (WORD_BYTES != WORD_BYTES_EXT) begin : g_check
    $error("tps_source: WORD_BYTES must be 16384.");
  end

  // Key and strap synchronisers; a change counts once stages two and three agree.
  logic [KEY_COUNT-1:0] sync1_reg;
  logic [KEY_COUNT-1:0] sync2_reg;
  logic [KEY_COUNT-1:0] sync3_reg;
  logic [KEY_COUNT-1:0] filt_reg;
  logic [KEY_COUNT-1:0] filt_prev_reg;
  logic [KEY_COUNT-1:0] filt_next;
  logic [KEY_COUNT-1:0] press_w;

  assign filt_next = (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg | sync3_reg));
  assign press_w = filt_reg & ~filt_prev_reg;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      filt_reg <= '0;
      filt_prev_reg <= '0;
    end else begin
      sync1_reg <= {prom_option_i, extended_memory_option_i, down_key_i, up_key_i,
                    recall_key_i, word_key_i, prbs_key_i, lock_key_i};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg <= filt_next;
      filt_prev_reg <= filt_reg;
    end
  end

  logic ext_w;
  logic prom_w;
  assign ext_w = filt_reg[KEY_EXT_OPT];
  assign prom_w = filt_reg[KEY_PROM_OPT] & ext_w;

  // Lockout toggles on each press of the lock key.
  logic locked_reg;
  logic accept_w;
  assign accept_w = ~locked_reg;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      locked_reg <= 1'b0;
    end else if (press_w[KEY_LOCK]) begin
      locked_reg <= ~locked_reg;
    end
  end

  assign lock_led_o = locked_reg;

  // Recall index stepping with unavailable entries skipped.
  function automatic logic [4:0] recall_last(input logic ext, input logic prom);
    if (prom) begin
      recall_last = RECALL_LAST_PROM;
    end else if (ext) begin
      recall_last = RECALL_LAST_EXT;
    end else begin
      recall_last = RECALL_LAST_BASIC;
    end
  endfunction : recall_last

  function automatic logic [4:0] recall_step(input logic [4:0] idx, input logic up,
                                             input logic [4:0] last);
    if (up) begin
      recall_step = (idx >= last) ? 5'h00 : idx + 5'h01;
    end else begin
      recall_step = (idx == 5'h00 || idx > last) ? last : idx - 5'h01;
    end
  endfunction : recall_step

  // Selection state shared by generator and analyzer use.
  tps_mode_t mode_reg;
  tps_mode_t mode_next;
  logic [2:0] prbs_idx_reg;
  logic [2:0] prbs_idx_next;
  logic [4:0] recall_idx_reg;
  logic [4:0] recall_idx_next;
  logic [4:0] last_w;
  logic [4:0] recall_eff_w;
  logic key_up_w;
  logic key_down_w;

  assign last_w = recall_last(ext_w, prom_w);
  assign recall_eff_w = (recall_idx_reg > last_w) ? 5'h00 : recall_idx_reg;
  assign key_up_w = accept_w & press_w[KEY_UP];
  assign key_down_w = accept_w & press_w[KEY_DOWN];

  always_comb begin
    mode_next = mode_reg;
    prbs_idx_next = prbs_idx_reg;
    recall_idx_next = recall_eff_w;
    if (accept_w) begin
      if (press_w[KEY_PRBS]) begin
        mode_next = MODE_PRBS;
      end else if (press_w[KEY_WORD]) begin
        mode_next = MODE_WORD;
      end else if (press_w[KEY_RECALL]) begin
        mode_next = MODE_RECALL;
      end else begin
        case (mode_reg)
          MODE_PRBS: begin
            if (key_up_w) begin
              prbs_idx_next = (prbs_idx_reg >= PRBS_LAST) ? 3'h0 : prbs_idx_reg + 3'h1;
            end else if (key_down_w) begin
              prbs_idx_next = (prbs_idx_reg == 3'h0) ? PRBS_LAST : prbs_idx_reg - 3'h1;
            end
          end
          MODE_RECALL: begin
            if (key_up_w || key_down_w) begin
              recall_idx_next = recall_step(recall_eff_w, key_up_w, last_w);
            end
          end
          MODE_WORD: begin
            recall_idx_next = recall_eff_w;
          end
          default: begin
            mode_next = MODE_PRBS;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      mode_reg <= MODE_PRBS;
      prbs_idx_reg <= 3'h0;
      recall_idx_reg <= 5'h00;
    end else begin
      mode_reg <= mode_next;
      prbs_idx_reg <= prbs_idx_next;
      recall_idx_reg <= recall_idx_next;
    end
  end

  // Active source and display label follow the displayed choice directly.
  tps_src_t src_w;
  logic [3:0] word_slot_w;
  logic [2:0] mark_idx_w;
  logic [3:0] prom_idx_w;
  logic [4:0] label_w;

  assign mark_idx_w = 3'(recall_eff_w - RECALL_MARK_FIRST);
  assign prom_idx_w = 4'(recall_eff_w - RECALL_PROM_FIRST);

  always_comb begin
    src_w = SRC_PRBS;
    word_slot_w = WORD_CURRENT_SLOT;
    label_w = 5'(prbs_order7_label + {2'b00, prbs_idx_reg});
    case (mode_reg)
      MODE_PRBS: begin
        src_w = SRC_PRBS;
      end
      MODE_WORD: begin
        src_w = SRC_WORD;
        label_w = CURRENT_WORD_LABEL;
      end
      MODE_RECALL: begin
        if (recall_eff_w < RECALL_MARK_FIRST) begin
          src_w = SRC_WORD;
          word_slot_w = recall_eff_w[3:0];
          label_w = 5'(WORD_SLOT0_LABEL + recall_eff_w);
        end else if (recall_eff_w < RECALL_PROM_FIRST) begin
          src_w = SRC_MARK;
          label_w = 5'(eighth_ones_density_label + {2'b00, mark_idx_w});
        end else begin
          src_w = SRC_PROM;
          label_w = 5'(PROM0_LABEL + {1'b0, prom_idx_w});
        end
      end
      default: begin
        src_w = SRC_PRBS;
      end
    endcase
  end

  // Any change of the active choice restarts the pattern from its start.
  logic [4:0] label_prev_reg;
  logic restart_w;
  assign restart_w = (label_w != label_prev_reg);

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      label_prev_reg <= prbs_order7_label;
    end else begin
      label_prev_reg <= label_w;
    end
  end

  // Retained word storage: eight saved slots plus the current word, no reset.
  logic [7:0] word_mem [0:WORD_SLOTS*WORD_BYTES-1];
  logic [16:0] word_len_m1_mem [0:WORD_SLOTS-1];
  logic wr_ok_w;
  logic len_ok_w;
  logic [16:0] len_cap_w;

  assign wr_ok_w = wr_en_i & accept_w & (wr_slot_i <= WORD_CURRENT_SLOT)
                   & (ext_w | (wr_byte_i <= WORD_BYTES_BASIC_LAST));
  assign len_ok_w = len_wr_i & accept_w & (wr_slot_i <= WORD_CURRENT_SLOT);
  assign len_cap_w = (!ext_w && len_m1_i > WORD_LEN_M1_BASIC) ? WORD_LEN_M1_BASIC
                     : len_m1_i;

  always_ff @(posedge clk_i) begin
    if (wr_ok_w) begin
      word_mem[{wr_slot_i, wr_byte_i}] <= wr_data_i;
    end
    if (len_ok_w) begin
      word_len_m1_mem[wr_slot_i] <= len_cap_w;
    end
  end

  // Bit position walks the word or fixed pattern and wraps after the last bit.
  logic [16:0] bit_pos_reg;
  logic [16:0] bit_pos_next;
  logic [16:0] word_len_raw_w;
  logic [16:0] word_last_w;
  logic [16:0] cur_last_w;
  logic [7:0] word_byte_w;
  logic word_bit_w;
  logic prom_bit_w;

  assign word_len_raw_w = word_len_m1_mem[word_slot_w];
  assign word_last_w = (!ext_w && word_len_raw_w > WORD_LEN_M1_BASIC) ? WORD_LEN_M1_BASIC
                       : word_len_raw_w;
  assign cur_last_w = (src_w == SRC_PROM) ? PROM_LEN_M1 : word_last_w;
  assign bit_pos_next = (bit_pos_reg >= cur_last_w) ? 17'h00000 : bit_pos_reg + 17'h00001;
  assign word_byte_w = word_mem[{word_slot_w, bit_pos_reg[16:3]}];
  assign word_bit_w = word_byte_w[3'h7 - bit_pos_reg[2:0]];
  assign prom_bit_w = PROM_PATTERN[prom_idx_w][4'hf - bit_pos_reg[3:0]];

  always_ff @(posedge clk_i) begin
    if (!resetn_i || restart_w) begin
      bit_pos_reg <= 17'h00000;
    end else begin
      bit_pos_reg <= bit_pos_next;
    end
  end

  // Pattern generators.
  logic prbs_bit_w;
  logic mark_bit_w;

  tps_prbs u_prbs (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .restart_i(restart_w),
    .order_sel_i(prbs_idx_reg),
    .bit_o(prbs_bit_w)
  );

  tps_mark u_mark (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .restart_i(restart_w),
    .density_sel_i(mark_idx_w),
    .bit_o(mark_bit_w)
  );

  // Output bit, restart flag and displayed label are registered.
  logic pattern_bit_reg;
  logic pattern_bit_next;
  logic restart_reg;
  logic [4:0] label_reg;
  logic [1:0] src_reg;

  always_comb begin
    case (src_w)
      SRC_PRBS: pattern_bit_next = prbs_bit_w;
      SRC_WORD: pattern_bit_next = word_bit_w;
      SRC_MARK: pattern_bit_next = mark_bit_w;
      SRC_PROM: pattern_bit_next = prom_bit_w;
      default: pattern_bit_next = prbs_bit_w;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pattern_bit_reg <= 1'b0;
      restart_reg <= 1'b0;
      label_reg <= prbs_order7_label;
      src_reg <= 2'h0;
    end else begin
      pattern_bit_reg <= pattern_bit_next;
      restart_reg <= restart_w;
      label_reg <= label_w;
      src_reg <= src_w;
    end
  end

  assign pattern_bit_o = pattern_bit_reg;
  assign restart_o = restart_reg;
  assign display_label_o = label_reg;
  assign active_source_o = src_reg;

endmodule : tps_source

// ==== sim/tps_source_monitor.sv ====
// Concurrent checks on the ports of the pattern source.
`timescale 1ns/1ps
module tps_source_monitor
  import tps_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic lock_key_i,
  input wire logic extended_memory_option_i,
  input wire logic restart_o,
  input wire logic lock_led_o,
  input wire logic [4:0] display_label_o,
  input wire logic [1:0] active_source_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  AST_RESET_STATE: assert property (disable iff (1'b0) !resetn_i |=> !lock_led_o && !restart_o
    && display_label_o == 5'h00 && active_source_o == 2'h0) else $error("Bad reset state.");
  AST_RESTART_PULSE: assert property (restart_o |=> !restart_o)
    else $error("Restart longer than one cycle.");
  AST_CHANGE_RESTARTS: assert property ($changed(display_label_o) |-> restart_o)
    else $error("Choice changed without restart.");
  AST_LOCK_TOGGLES: assert property ($rose(lock_key_i) |-> ##5 $changed(lock_led_o))
    else $error("Lock key did not toggle lock.");
  AST_LOCKED_FROZEN: assert property (lock_led_o [*6] |-> $stable(display_label_o))
    else $error("Choice changed while locked.");
  AST_NO_OPTION: assert property ((!extended_memory_option_i) [*8] |-> active_source_o <= 2'h1)
    else $error("Option pattern active without option.");
  AST_PRBS_SRC: assert property ($stable(display_label_o) && display_label_o <= 5'h04
    |-> active_source_o == SRC_PRBS) else $error("Order label without sequence source.");
  AST_WORD_SRC: assert property ($stable(display_label_o) && display_label_o inside {[5'h05:5'h0d]}
    |-> active_source_o == SRC_WORD) else $error("Word label without word source.");
  AST_MARK_SRC: assert property ($stable(display_label_o) && display_label_o inside {[5'h0e:5'h12]}
    |-> active_source_o == SRC_MARK) else $error("Density label without density source.");
  AST_PROM_SRC: assert property ($stable(display_label_o) && display_label_o >= 5'h13
    |-> active_source_o == SRC_PROM) else $error("Fixed label without fixed source.");
endmodule : tps_source_monitor

bind tps_source tps_source_monitor tps_source_monitor_i (.clk_i(clk_i), .resetn_i(resetn_i),
  .lock_key_i(lock_key_i), .extended_memory_option_i(extended_memory_option_i),
  .restart_o(restart_o), .lock_led_o(lock_led_o), .display_label_o(display_label_o),
  .active_source_o(active_source_o));

// ==== sim/tps_dut_rx.sv ====
// Receiving device under test that counts the bits and ones it sees.
`timescale 1ns/1ps
module tps_dut_rx (
  input wire logic clk_i,
  input wire logic clear_i,
  input wire logic bit_i,
  output int ones_o,
  output int bits_o
);
  always_ff @(posedge clk_i) begin
    if (clear_i) begin
      ones_o <= 0;
      bits_o <= 0;
    end else begin
      ones_o <= ones_o + int'(bit_i === 1'b1);
      bits_o <= bits_o + 1;
    end
  end
endmodule : tps_dut_rx

// ==== sim/tb.sv ====
// Self-checking bench of the pattern source.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_compared++; if ((e) !== (s)) begin fail_count++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, s); end end
module tb;
  import tps_pkg::*;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [5:0] key = 6'h00;
  logic ext = 1'b0;
  logic prom = 1'b0;
  logic wr_en = 1'b0;
  logic len_wr = 1'b0;
  logic [3:0] slot = 4'h0;
  logic [13:0] wbyte = 14'h0000;
  logic [7:0] wdata = 8'h00;
  logic [16:0] len = 17'h00000;
  logic clr = 1'b1;
  logic rst_seen = 1'b0;
  logic bit_o, restart_o, lock_led_o;
  logic [4:0] label_o;
  logic [1:0] src_o;
  int ones, nbits;
  int fail_count = 0;
  int n_compared = 0;
  int dens [0:4] = '{1, 2, 4, 6, 7};
  logic b [0:999];
  tps_source tps_source_i (.clk_i(clk_i), .resetn_i(resetn_i), .lock_key_i(key[KEY_LOCK]),
    .prbs_key_i(key[KEY_PRBS]), .word_key_i(key[KEY_WORD]), .recall_key_i(key[KEY_RECALL]),
    .up_key_i(key[KEY_UP]), .down_key_i(key[KEY_DOWN]), .extended_memory_option_i(ext),
    .prom_option_i(prom), .wr_en_i(wr_en), .wr_slot_i(slot), .wr_byte_i(wbyte),
    .wr_data_i(wdata), .len_wr_i(len_wr), .len_m1_i(len), .pattern_bit_o(bit_o),
    .restart_o(restart_o), .lock_led_o(lock_led_o), .display_label_o(label_o),
    .active_source_o(src_o));
  tps_dut_rx tps_dut_rx_i (.clk_i(clk_i), .clear_i(clr), .bit_i(bit_o), .ones_o(ones),
    .bits_o(nbits));
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (restart_o === 1'b1) rst_seen <= 1'b1;
  task automatic print_verdict;
    $display("Compared %0d, mismatches %0d.", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  task automatic press(input int k);
    rst_seen = 1'b0;
    @(posedge clk_i) key[k] <= 1'b1;
    repeat (5) @(posedge clk_i);
    key[k] <= 1'b0;
    repeat (5) @(posedge clk_i);
    #1;
  endtask : press
  task automatic sel(input int k, input logic [4:0] lab, input logic [1:0] src);
    press(k);
    `CHK("restart", 1'b1, rst_seen)
    `CHK("label", lab, label_o)
    `CHK("source", src, src_o)
  endtask : sel
  task automatic grab(input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge clk_i) #1;
      b[k] = bit_o;
    end
  endtask : grab
  task automatic prbs_chk(input int i, input int n);
    int o, t, run, mx, on;
    o = PRBS_ORDER[i];
    t = PRBS_TAP[i];
    run = 0;
    mx = 0;
    on = 0;
    grab(n);
    for (int k = 0; k < n; k++) begin
      if (k >= o) `CHK("prbs bit", b[k-o] ^ b[k-t], b[k])
      if (o == 7 && k >= 127) `CHK("period", b[k-127], b[k])
      run = (b[k] === 1'b0) ? run + 1 : 0;
      mx = (run > mx) ? run : mx;
      if (k < 127) on += int'(b[k] === 1'b1);
    end
    if (o == 7) begin
      `CHK("ones", 64, on)
      `CHK("zero run", 6, mx)
    end
  endtask : prbs_chk
  task automatic word_chk(input logic [31:0] p, input int n);
    int ok, m;
    ok = 0;
    grab(3 * n);
    for (int r = 0; r < n; r++) begin
      m = 1;
      for (int k = 0; k < 3 * n; k++) if (b[k] !== p[31 - (k + r) % n]) m = 0;
      if (m == 1) ok = 1;
    end
    `CHK("word", 1, ok)
  endtask : word_chk
  task automatic store(input logic [3:0] s, input logic [31:0] p, input logic [16:0] l);
    for (int k = 0; k < 5; k++) begin
      @(posedge clk_i);
      slot <= s;
      wbyte <= 14'(k);
      wdata <= p[31 - 8 * (k % 4) -: 8];
      wr_en <= (k < 4);
      len_wr <= (k == 4);
      len <= l;
    end
    @(posedge clk_i);
    wr_en <= 1'b0;
    len_wr <= 1'b0;
  endtask : store
  initial begin
    logic [31:0] p;
    int d, m;
    void'($urandom(23562));
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i) #1;
    `CHK("reset label", prbs_order7_label, label_o)
    `CHK("reset lock", 1'b0, lock_led_o)
    prbs_chk(0, 260);
    for (int i = 1; i < PRBS_COUNT; i++) begin
      sel(KEY_UP, 5'(i), SRC_PRBS);
      prbs_chk(i, 120);
    end
    press(KEY_LOCK);
    `CHK("lock led", 1'b1, lock_led_o)
    press(KEY_DOWN);
    `CHK("locked label", prbs_order23_label, label_o)
    `CHK("locked restart", 1'b0, rst_seen)
    press(KEY_LOCK);
    `CHK("unlock led", 1'b0, lock_led_o)
    p = $urandom;
    store(WORD_CURRENT_SLOT, p, 17'h0001f);
    sel(KEY_WORD, CURRENT_WORD_LABEL, SRC_WORD);
    word_chk(p, 16);
    @(posedge clk_i);
    ext <= 1'b1;
    prom <= 1'b1;
    repeat (6) @(posedge clk_i);
    p = $urandom;
    store(4'h3, p, 17'h0001b);
    sel(KEY_RECALL, WORD_SLOT0_LABEL, SRC_WORD);
    for (int i = 1; i < 8; i++) begin
      sel(KEY_UP, WORD_SLOT0_LABEL + 5'(i), SRC_WORD);
      if (i == 3) word_chk(p, 28);
    end
    for (d = 0; d < 5; d++) begin
      sel(KEY_UP, eighth_ones_density_label + 5'(d), SRC_MARK);
      @(posedge clk_i) clr <= 1'b0;
      grab(800);
      clr <= 1'b1;
      m = 0;
      for (int k = 8; k < 800; k++) m += int'(b[k] !== b[k-8]);
      `CHK("randomised", 1'b1, m > 20)
      `CHK("density", 1'b1, (ones * 8 - dens[d] * nbits) inside {[-400:400]})
    end
    sel(KEY_UP, PROM0_LABEL, SRC_PROM);
    word_chk({PROM_PATTERN[0], 16'h0000}, 16);
    rst_seen = 1'b0;
    @(posedge clk_i) ext <= 1'b0;
    for (d = 0; d < 20 && rst_seen !== 1'b1; d++) @(posedge clk_i);
    #1;
    `CHK("clamp restart", 1'b1, rst_seen)
    `CHK("clamp label", WORD_SLOT0_LABEL, label_o)
    print_verdict;
  end
endmodule : tb
